// ===== pfh_consts.svh
// timing counts and widths for the parallel fifo host port
`ifndef PFH_CONSTS_SVH
`define PFH_CONSTS_SVH
`define PFH_CLK_NS 50
`define PFH_DATA_W 8
`define PFH_RX_FLAG_HOLD_NS 80
`define PFH_RX_FLAG_HOLD_CYC ((`PFH_RX_FLAG_HOLD_NS + `PFH_CLK_NS - 1) / `PFH_CLK_NS)
`define PFH_TX_FLAG_HOLD_NS 80
`define PFH_TX_FLAG_HOLD_CYC ((`PFH_TX_FLAG_HOLD_NS + `PFH_CLK_NS - 1) / `PFH_CLK_NS)
`define PFH_FIFO_DEPTH 16
`endif

// ===== pfh_pkg.sv
// types shared by the parallel fifo host port
package pfh_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_HOLD} pfh_flag_t;
endpackage : pfh_pkg

// ===== pfh_fifo_if.sv
// push/pop carrier between the port and its fifo
`timescale 1ns/1ns
interface pfh_fifo_if #(parameter int W = 8);
    logic push;
    logic [W-1:0] wdata;
    logic pop;
    logic [W-1:0] rdata;
    logic notEmpty;
    logic notFull;
    modport owner (output push, output wdata, output pop, input rdata, input notEmpty, input notFull);
    modport store (input push, input wdata, input pop, output rdata, output notEmpty, output notFull);
endinterface : pfh_fifo_if

// ===== pfh_fifo.sv
// flip-flop fifo used for both directions
`timescale 1ns/1ns
`include "pfh_consts.svh"
module pfh_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // fifo side
    pfh_fifo_if.store fif
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_ff [DEPTH];
    logic [W-1:0] nxt_mem [DEPTH];
    logic [AW-1:0] wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
    logic [AW:0] count_ff, nxt_count;
    logic doPush, doPop;

    assign fif.rdata = mem_ff[rdPtr_ff];
    assign fif.notEmpty = (count_ff != '0);
    assign fif.notFull = (count_ff != (AW+1)'(DEPTH));

    always_comb begin
        doPush = fif.push && fif.notFull;
        doPop = fif.pop && fif.notEmpty;
        nxt_mem = mem_ff;
        nxt_wrPtr = wrPtr_ff;
        nxt_rdPtr = rdPtr_ff;
        if (doPush) begin
            nxt_mem[wrPtr_ff] = fif.wdata;
            nxt_wrPtr = (wrPtr_ff == (AW)'(DEPTH - 1)) ? '0 : wrPtr_ff + 1'b1;
        end
        if (doPop) begin
            nxt_rdPtr = (rdPtr_ff == (AW)'(DEPTH - 1)) ? '0 : rdPtr_ff + 1'b1;
        end
        nxt_count = count_ff + (AW+1)'(doPush) - (AW+1)'(doPop);
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= '0;
            end
        end else begin
            wrPtr_ff <= nxt_wrPtr;
            rdPtr_ff <= nxt_rdPtr;
            count_ff <= nxt_count;
            mem_ff <= nxt_mem;
        end
    end
endmodule : pfh_fifo

// ===== pfh_parallel_fifo_host_port.sv
// device end of the byte-wide parallel fifo host port
// Notes on behaviour
// RQ1: rx_avail_n low while a receive byte waits, high when none.
// RQ2: host reads only after seeing rx_avail_n low.
// RQ3: while read strobe low, current receive byte drives data bus, bit 0 lsb.
// RQ4: each falling read strobe consumes one receive byte.
// RQ5: tx_space_n low when transmit fifo can take a byte, else high.
// RQ6: host writes only while tx_space_n low, strobe high then low.
// RQ7: falling write strobe captures bus byte into transmit fifo.
// RQ8: after read strobe rises, rx_avail_n goes high quickly, stays high 80 ns.
// RQ9: after write strobe falls, tx_space_n goes high, stays high 80 ns.
// RQ10: host keeps read strobe high 50 ns plus flag-inactive time between reads.
// RQ11: data bus released whenever read strobe is high.
`timescale 1ns/1ns
`include "pfh_consts.svh"
module pfh_parallel_fifo_host_port #(
    parameter int DEPTH = `PFH_FIFO_DEPTH,
    parameter int RX_HOLD = `PFH_RX_FLAG_HOLD_CYC,
    parameter int TX_HOLD = `PFH_TX_FLAG_HOLD_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // host pins
    input wire logic [7:0] fifoBusIn,
    output logic [7:0] fifoBusOut,
    output logic fifoBusOe,
    input wire logic rdStrobe_n,
    input wire logic wrStrobe,
    output logic rx_avail_n,
    output logic tx_space_n,
    // internal side: bytes toward the host
    input wire logic rxPush,
    input wire logic [7:0] rxData,
    output logic rxReady,
    // internal side: bytes from the host
    output logic txValid,
    output logic [7:0] txData,
    input wire logic txPop
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [1:0] rdSync_ff, wrSync_ff;
    logic rdLast_ff, wrLast_ff;
    logic [7:0] busSync1_ff, busSync2_ff;
    logic rdFall, rdRise, wrFall;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdSync_ff <= 2'h3;
            wrSync_ff <= 2'h0;
            rdLast_ff <= 1'b1;
            wrLast_ff <= 1'b0;
            busSync1_ff <= 8'h00;
            busSync2_ff <= 8'h00;
        end else begin
            rdSync_ff <= {rdSync_ff[0], rdStrobe_n};
            wrSync_ff <= {wrSync_ff[0], wrStrobe};
            rdLast_ff <= rdSync_ff[1];
            wrLast_ff <= wrSync_ff[1];
            busSync1_ff <= fifoBusIn;
            busSync2_ff <= busSync1_ff;
        end
    end

    // data held through the strobe; synchronised copy lags the strobe equally
    assign rdFall = rdLast_ff && !rdSync_ff[1];
    assign rdRise = !rdLast_ff && rdSync_ff[1];
    assign wrFall = wrLast_ff && !wrSync_ff[1];

    // ****************************************
    // fifos
    // ****************************************
    pfh_fifo_if #(.W(8)) rxIf ();
    pfh_fifo_if #(.W(8)) txIf ();

    pfh_fifo #(.W(8), .DEPTH(DEPTH)) u_rx (.clk_sys(clk_sys), .reset_n(reset_n), .fif(rxIf.store));
    pfh_fifo #(.W(8), .DEPTH(DEPTH)) u_tx (.clk_sys(clk_sys), .reset_n(reset_n), .fif(txIf.store));

    assign rxIf.push = rxPush;
    assign rxIf.wdata = rxData;
    assign rxIf.pop = rdFall; // [RQ4]
    assign txIf.push = wrFall; // [RQ7]
    assign txIf.wdata = busSync2_ff; // [RQ7]
    assign txIf.pop = txPop;
    assign rxReady = rxIf.notFull;
    assign txValid = txIf.notEmpty;
    assign txData = txIf.rdata;

    // ****************************************
    // flag and bus state
    // ****************************************
    pfh_pkg::pfh_flag_t rxSt_ff, nxt_rxSt, txSt_ff, nxt_txSt;
    logic [3:0] rxCnt_ff, nxt_rxCnt, txCnt_ff, nxt_txCnt;
    logic nxt_rxAvail_n, nxt_txSpace_n, nxt_oe;
    logic [7:0] nxt_busOut;

    always_comb begin
        nxt_rxSt = rxSt_ff;
        nxt_rxCnt = rxCnt_ff;
        nxt_txSt = txSt_ff;
        nxt_txCnt = txCnt_ff;
        case (rxSt_ff)
            pfh_pkg::ST_IDLE: if (rdFall) nxt_rxSt = pfh_pkg::ST_BUSY;
            pfh_pkg::ST_BUSY: begin
                if (rdRise) begin
                    nxt_rxSt = pfh_pkg::ST_HOLD;
                    nxt_rxCnt = 4'(RX_HOLD);
                end
            end
            pfh_pkg::ST_HOLD: begin
                if (rxCnt_ff <= 4'h1) nxt_rxSt = pfh_pkg::ST_IDLE;
                else nxt_rxCnt = rxCnt_ff - 4'h1;
            end
            default: nxt_rxSt = pfh_pkg::ST_IDLE;
        endcase
        case (txSt_ff)
            pfh_pkg::ST_IDLE: begin
                if (wrFall) begin
                    nxt_txSt = pfh_pkg::ST_HOLD;
                    nxt_txCnt = 4'(TX_HOLD);
                end
            end
            pfh_pkg::ST_HOLD: begin
                if (txCnt_ff <= 4'h1) nxt_txSt = pfh_pkg::ST_IDLE;
                else nxt_txCnt = txCnt_ff - 4'h1;
            end
            default: nxt_txSt = pfh_pkg::ST_IDLE;
        endcase
        // flag goes high on the falling read strobe and stays up through busy and the hold [RQ8]
        nxt_rxAvail_n = !(nxt_rxSt == pfh_pkg::ST_IDLE && rxIf.notEmpty && !rdFall); // [RQ1]
        // rising write edge already flags busy so no second write slips in [RQ9]
        nxt_txSpace_n = !(nxt_txSt == pfh_pkg::ST_IDLE && txIf.notFull && !wrFall && !wrSync_ff[1]); // [RQ5]
        nxt_oe = !rdSync_ff[1]; // [RQ11]
        nxt_busOut = rxIf.rdata; // [RQ3]
        if (rxSt_ff == pfh_pkg::ST_BUSY) nxt_busOut = fifoBusOut; // keep byte stable after its pop
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rxSt_ff <= pfh_pkg::ST_IDLE;
            txSt_ff <= pfh_pkg::ST_IDLE;
            rxCnt_ff <= 4'h0;
            txCnt_ff <= 4'h0;
            rx_avail_n <= 1'b1;
            tx_space_n <= 1'b1;
            fifoBusOe <= 1'b0;
            fifoBusOut <= 8'h00;
        end else begin
            rxSt_ff <= nxt_rxSt;
            txSt_ff <= nxt_txSt;
            rxCnt_ff <= nxt_rxCnt;
            txCnt_ff <= nxt_txCnt;
            rx_avail_n <= nxt_rxAvail_n;
            tx_space_n <= nxt_txSpace_n;
            fifoBusOe <= nxt_oe;
            fifoBusOut <= nxt_busOut;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_rx_empty_flag;
        @(posedge clk_sys) disable iff (!reset_n) !rxIf.notEmpty |=> rx_avail_n;
    endproperty
    a_rx_empty_flag: assert property (p_rx_empty_flag) else $error("rx flag low with empty fifo"); // [RQ1]

    // pin runs through both sync flops and then the oe flop, hence three cycles
    property p_oe_follows;
        @(posedge clk_sys) disable iff (!reset_n) rdStrobe_n |-> ##3 !fifoBusOe;
    endproperty
    a_oe_follows: assert property (p_oe_follows) else $error("bus driven with read strobe high"); // [RQ11]

    property p_oe_on;
        @(posedge clk_sys) disable iff (!reset_n) !rdStrobe_n |-> ##3 fifoBusOe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("bus not driven during read"); // [RQ3]

    property p_rd_pop;
        @(posedge clk_sys) disable iff (!reset_n) rdFall && rxIf.notEmpty |=> $past(rxIf.rdata) == fifoBusOut;
    endproperty
    a_rd_pop: assert property (p_rd_pop) else $error("wrong byte on read"); // [RQ4]

    property p_rx_hold;
        @(posedge clk_sys) disable iff (!reset_n) rdRise |=> rx_avail_n [*2];
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx flag hold too short"); // [RQ8]

    property p_tx_hold;
        @(posedge clk_sys) disable iff (!reset_n) wrFall |=> tx_space_n [*2];
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx flag hold too short"); // [RQ9]

    property p_tx_full;
        @(posedge clk_sys) disable iff (!reset_n) !txIf.notFull |=> tx_space_n;
    endproperty
    a_tx_full: assert property (p_tx_full) else $error("tx flag low with full fifo"); // [RQ5]

    property p_wr_capture;
        @(posedge clk_sys) disable iff (!reset_n) wrFall && txIf.notFull && !txIf.notEmpty && !txPop |=> txValid && txData == $past(busSync2_ff);
    endproperty
    a_wr_capture: assert property (p_wr_capture) else $error("write byte not captured"); // [RQ7]

    // byte must not move under the host while the bus is driven
    property p_rd_bus_stable;
        @(posedge clk_sys) disable iff (!reset_n) fifoBusOe && $past(fifoBusOe) |-> $stable(fifoBusOut);
    endproperty
    a_rd_bus_stable: assert property (p_rd_bus_stable) else $error("read byte changed while driven"); // [RQ3]

    property p_rx_busy;
        @(posedge clk_sys) disable iff (!reset_n) !rdStrobe_n |-> ##3 rx_avail_n;
    endproperty
    a_rx_busy: assert property (p_rx_busy) else $error("rx flag low during read strobe"); // [RQ8]

    property p_tx_busy;
        @(posedge clk_sys) disable iff (!reset_n) wrStrobe |-> ##3 tx_space_n;
    endproperty
    a_tx_busy: assert property (p_tx_busy) else $error("tx flag low during write strobe"); // [RQ9]

    // sampled reset keeps the release edge out, flag is still in reset there
    property p_tx_space_on;
        @(posedge clk_sys) disable iff (!reset_n)
            reset_n && txIf.notFull && txSt_ff == pfh_pkg::ST_IDLE && !wrSync_ff[1] && !wrLast_ff |=> !tx_space_n;
    endproperty
    a_tx_space_on: assert property (p_tx_space_on) else $error("tx flag high with room"); // [RQ5]

    property p_rx_avail_on;
        @(posedge clk_sys) disable iff (!reset_n)
            reset_n && rxIf.notEmpty && rxSt_ff == pfh_pkg::ST_IDLE && rdSync_ff[1] && rdLast_ff |=> !rx_avail_n;
    endproperty
    a_rx_avail_on: assert property (p_rx_avail_on) else $error("rx flag high with byte waiting"); // [RQ1]
endmodule : pfh_parallel_fifo_host_port

// ===== pfh_host_model.sv
// host-side partner model of the parallel fifo port
`timescale 1ns/1ns
module pfh_host_model (
    // clock
    input wire logic clk_sys,
    // device pins
    input wire logic [7:0] fifoBusOut,
    input wire logic fifoBusOe,
    input wire logic rx_avail_n,
    input wire logic tx_space_n,
    // host drives
    output logic [7:0] fifoBusIn,
    output logic rdStrobe_n,
    output logic wrStrobe
);
    logic hostDrv = 1'b0;
    logic [7:0] hostData = 8'h00;
    logic [7:0] lastBus = 8'h00;
    // floating bus toggles, so a stale byte never passes as a read
    assign fifoBusIn = fifoBusOe ? fifoBusOut : (hostDrv ? hostData : ~lastBus);
    always_ff @(posedge clk_sys) lastBus <= fifoBusIn;
    initial begin
        rdStrobe_n = 1'b1;
        wrStrobe = 1'b0;
    end
    task automatic wait_low(input bit useRx, output bit ok);
        ok = 1'b0;
        for (int i = 0; i < 100 && !ok; i++) begin
            @(posedge clk_sys);
            ok = ((useRx ? rx_avail_n : tx_space_n) === 1'b0);
        end
    endtask : wait_low
    task automatic read_byte(output logic [7:0] d, output bit ok, output bit tOk);
        wait_low(1'b1, ok);
        tOk = ok;
        // never strobe against a high flag, even after a timeout
        if (!ok) return;
        rdStrobe_n <= 1'b0;
        repeat (5) @(posedge clk_sys);
        #1 d = fifoBusIn;
        tOk &= (rx_avail_n === 1'b1);
        @(posedge clk_sys) rdStrobe_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 tOk &= (rx_avail_n === 1'b1);
        repeat (2) @(posedge clk_sys);
        #1 tOk &= (fifoBusOe === 1'b0);
    endtask : read_byte
    task automatic write_byte(input logic [7:0] d, output bit ok, output bit tOk);
        wait_low(1'b0, ok);
        tOk = 1'b0;
        if (!ok) return;
        hostDrv <= 1'b1;
        hostData <= d;
        // data settles one cycle before the strobe rises and six cycles before it falls
        repeat (2) @(posedge clk_sys) wrStrobe <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 tOk = (tx_space_n === 1'b1);
        @(posedge clk_sys) wrStrobe <= 1'b0;
        repeat (3) @(posedge clk_sys);
        hostDrv <= 1'b0;
    endtask : write_byte
endmodule : pfh_host_model

// ===== testbench.sv
// self-checking bench for the parallel fifo host port
`timescale 1ns/1ns
module testbench;
    logic clk_sys = 1'b0, reset_n = 1'b0, rxPush = 1'b0, txPop = 1'b0;
    logic [7:0] rxData = 8'h00, fifoBusIn, fifoBusOut, txData, d;
    logic fifoBusOe, rdStrobe_n, wrStrobe, rx_avail_n, tx_space_n, rxReady, txValid;
    int error_cnt = 0, comparisons = 0, cyc = 0;
    bit ok, tOk;
    pfh_parallel_fifo_host_port pfh_parallel_fifo_host_port_i (.clk_sys(clk_sys), .reset_n(reset_n),
        .fifoBusIn(fifoBusIn), .fifoBusOut(fifoBusOut), .fifoBusOe(fifoBusOe), .rdStrobe_n(rdStrobe_n),
        .wrStrobe(wrStrobe), .rx_avail_n(rx_avail_n), .tx_space_n(tx_space_n), .rxPush(rxPush),
        .rxData(rxData), .rxReady(rxReady), .txValid(txValid), .txData(txData), .txPop(txPop));
    pfh_host_model pfh_host_model_i (.clk_sys(clk_sys), .fifoBusOut(fifoBusOut), .fifoBusOe(fifoBusOe),
        .rx_avail_n(rx_avail_n), .tx_space_n(tx_space_n), .fifoBusIn(fifoBusIn),
        .rdStrobe_n(rdStrobe_n), .wrStrobe(wrStrobe));
    initial forever #25 clk_sys = ~clk_sys;
    // ****************
    // checks and verdict
    // ****************
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
        end
    endtask : check_byte
    task automatic check_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
        end
    endtask : check_bit
    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    always @(posedge clk_sys) begin
        cyc++;
        // a hung handshake ends the run here
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    // ****************
    // scenarios
    // ****************
    task automatic push_rx(input logic [7:0] v);
        @(posedge clk_sys) rxPush <= 1'b1;
        rxData <= v;
        @(posedge clk_sys) rxPush <= 1'b0;
    endtask : push_rx
    task automatic pop_tx(input logic [7:0] exp);
        @(posedge clk_sys);
        #1 check_bit(txValid, 1'b1);
        check_byte(txData, exp);
        @(posedge clk_sys) txPop <= 1'b1;
        @(posedge clk_sys) txPop <= 1'b0;
    endtask : pop_tx
    task automatic test_idle;
        repeat (3) @(posedge clk_sys);
        #1 check_bit(rx_avail_n, 1'b1);
        check_bit(tx_space_n, 1'b0);
        check_bit(fifoBusOe, 1'b0);
        $display("test idle done");
    endtask : test_idle
    task automatic test_read;
        logic [7:0] v[3] = '{8'h01, 8'h80, 8'hA5};
        foreach (v[i]) push_rx(v[i]);
        foreach (v[i]) begin
            pfh_host_model_i.read_byte(d, ok, tOk);
            check_bit(ok, 1'b1);
            check_byte(d, v[i]);
            check_bit(tOk, 1'b1);
        end
        repeat (4) @(posedge clk_sys);
        #1 check_bit(rx_avail_n, 1'b1);
        $display("test read done");
    endtask : test_read
    task automatic test_write;
        pfh_host_model_i.write_byte(8'h3C, ok, tOk);
        check_bit(tOk, 1'b1);
        pfh_host_model_i.write_byte(8'hC3, ok, tOk);
        check_bit(ok, 1'b1);
        pop_tx(8'h3C);
        pop_tx(8'hC3);
        $display("test write done");
    endtask : test_write
    task automatic test_full;
        for (int i = 0; i < 16; i++) begin
            pfh_host_model_i.write_byte(8'(i * 17), ok, tOk);
            check_bit(ok, 1'b1);
        end
        repeat (6) @(posedge clk_sys);
        #1 check_bit(tx_space_n, 1'b1);
        for (int i = 0; i < 16; i++) pop_tx(8'(i * 17));
        repeat (6) @(posedge clk_sys);
        #1 check_bit(tx_space_n, 1'b0);
        $display("test full done");
    endtask : test_full
    task automatic test_rx_full;
        for (int i = 0; i < 16; i++) push_rx(8'(i * 5 + 2));
        #1 check_bit(rxReady, 1'b0);
        // seventeenth byte must be refused by the full receive fifo
        push_rx(8'hEE);
        for (int i = 0; i < 16; i++) begin
            pfh_host_model_i.read_byte(d, ok, tOk);
            check_bit(ok, 1'b1);
            check_byte(d, 8'(i * 5 + 2));
        end
        repeat (4) @(posedge clk_sys);
        #1 check_bit(rx_avail_n, 1'b1);
        check_bit(rxReady, 1'b1);
        $display("test rx full done");
    endtask : test_rx_full
    task automatic test_reset;
        push_rx(8'h5A);
        @(posedge clk_sys) reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 check_bit(rx_avail_n, 1'b1);
        check_bit(tx_space_n, 1'b1);
        @(posedge clk_sys) reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 check_bit(rx_avail_n, 1'b1);
        check_bit(tx_space_n, 1'b0);
        check_bit(fifoBusOe, 1'b0);
        $display("test reset done");
    endtask : test_reset
    initial begin
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        test_idle();
        test_read();
        test_write();
        test_full();
        test_rx_full();
        test_reset();
        print_verdict();
    end
endmodule : testbench
